// file: hw/op_exec_pkg.sv
package op_exec_pkg;

    localparam int IW = 14;
    localparam int PCW = 13;
    localparam int AW = 7;
    localparam int DW = 8;
    localparam int LW = 5;

    // instruction field and PC latch bit positions
    localparam int ADDR_LSB = 0;
    localparam int BIT_LSB = 7;
    localparam int BIT_MSB = 9;
    localparam int TGT_MSB = 10;
    localparam int TGT_LSB = 0;
    localparam int LATCH_LO = 3;
    localparam int LATCH_HI = 4;

    // opcode prefixes
    localparam logic [3:0] SKIP_SET_PFX = 4'h7;
    localparam int SKIP_PFX_LSB = 10;
    localparam logic [6:0] CLEAR_PFX = 7'h03;
    localparam int CLEAR_PFX_LSB = 7;
    localparam logic [2:0] CALL_PFX = 3'h4;
    localparam int CALL_PFX_LSB = 11;

    localparam logic [IW-1:0] IR_RST = 14'h0000;
    localparam logic [PCW-1:0] PC_RST = 13'h0000;
    localparam logic [PCW-1:0] PC_STEP = 13'h0001;
    localparam logic [LW-1:0] LATCH_RST = 5'h00;
    localparam logic [DW-1:0] CLEAR_VAL = 8'h00;

    typedef enum logic [1:0] {OP_OTHER, OP_SKIP, OP_CLEAR, OP_CALL} op_t;
    typedef enum logic [1:0] {SLOT_EMPTY, SLOT_EXEC, SLOT_NOP} slot_t;

    // instruction fetched by the core, with its address
    typedef struct packed {
        logic vld;
        logic [IW-1:0] word;
        logic [PCW-1:0] pc;
    } fetch_t;

    // strobes and data towards the datapath
    typedef struct packed {
        logic rf_we;
        logic [AW-1:0] rf_addr;
        logic [DW-1:0] rf_wdata;
        logic z_set;
        logic pc_load;
        logic [PCW-1:0] pc_target;
        logic push;
        logic [PCW-1:0] push_data;
        logic discard;
        logic nop_slot;
        logic foreign;
    } ctl_t;

    typedef struct packed {
        slot_t slot;
        logic [IW-1:0] ir;
        logic [PCW-1:0] ret;
        logic [LW-1:0] latch;
        logic kill;
    } state_t;

endpackage : op_exec_pkg

// file: hw/op_exec.sv
module op_exec
    import op_exec_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // fetch side
    input wire fetch_t fetch_in,
    input wire logic [LW-1:0] upper_pc_latch_in,
    // register file read data for the executing address
    input wire logic [DW-1:0] rf_rdata_in,
    // datapath control
    output ctl_t ctl_out
);

    state_t cur_ff;
    state_t nxt_cur;
    op_t op;
    logic bit_val;
    logic taken;
    // width of the bit-index operand
    localparam int BW = BIT_MSB - BIT_LSB + 1;
    // one lane per data bit: high when that bit is selected and reads one
    logic [DW-1:0] bit_hit;

    function automatic logic is_skip(input logic [IW-1:0] w);
        return w[IW-1:SKIP_PFX_LSB] == SKIP_SET_PFX;
    endfunction : is_skip

    function automatic logic is_clear(input logic [IW-1:0] w);
        return w[IW-1:CLEAR_PFX_LSB] == CLEAR_PFX;
    endfunction : is_clear

    function automatic logic is_call(input logic [IW-1:0] w);
        return w[IW-1:CALL_PFX_LSB] == CALL_PFX;
    endfunction : is_call

    // operand fields of an instruction word
    function automatic logic [AW-1:0] reg_field(input logic [IW-1:0] w);
        return w[ADDR_LSB+AW-1:ADDR_LSB];
    endfunction : reg_field

    function automatic logic [BW-1:0] bit_field(input logic [IW-1:0] w);
        return w[BIT_MSB:BIT_LSB];
    endfunction : bit_field

    function automatic logic [TGT_MSB:TGT_LSB] target_field(
        input logic [IW-1:0] w);
        return w[TGT_MSB:TGT_LSB];
    endfunction : target_field

    function automatic op_t decode(input logic [IW-1:0] w);
        op_t k;
        k = OP_OTHER;
        if (is_skip(w))
            k = OP_SKIP;
        else if (is_clear(w))
            k = OP_CLEAR;
        else if (is_call(w))
            k = OP_CALL;
        return k;
    endfunction : decode

    for (genvar i = 0; i < DW; i++)
    begin : g_bit_lane
        assign bit_hit[i] = rf_rdata_in[i]
            && (bit_field(cur_ff.ir) == BW'(i));
    end

    always_comb
    begin
        op = OP_OTHER;
        unique case (cur_ff.slot)
            SLOT_EXEC:
            begin
                op = decode(cur_ff.ir);
            end
            SLOT_NOP, SLOT_EMPTY:
            begin
                op = OP_OTHER;
            end
            default:
            begin
                op = OP_OTHER;
            end
        endcase
        // selected bit of the addressed register
        bit_val = |bit_hit;
        taken = 1'b0;
        unique case (op)
            OP_SKIP:
            begin
                taken = bit_val;
            end
            OP_CALL:
            begin
                taken = 1'b1;
            end
            OP_CLEAR, OP_OTHER:
            begin
                taken = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        nxt_cur = cur_ff;
        // a pending kill waits for the next fetched word
        if (taken)
        begin
            nxt_cur.kill = 1'b1;
        end
        if (fetch_in.vld)
        begin
            nxt_cur.ir = fetch_in.word;
            nxt_cur.ret = fetch_in.pc + PC_STEP;
            nxt_cur.latch = upper_pc_latch_in;
            if (taken || cur_ff.kill)
            begin
                nxt_cur.slot = SLOT_NOP;
                nxt_cur.kill = 1'b0;
            end
            else
            begin
                nxt_cur.slot = SLOT_EXEC;
            end
        end
        else
        begin
            nxt_cur.slot = SLOT_EMPTY;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            cur_ff.slot <= SLOT_EMPTY;
            cur_ff.ir <= IR_RST;
            cur_ff.ret <= PC_RST;
            cur_ff.latch <= LATCH_RST;
            cur_ff.kill <= 1'b0;
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    always_comb
    begin
        ctl_out.rf_addr = reg_field(cur_ff.ir);
        ctl_out.rf_wdata = CLEAR_VAL;
        ctl_out.pc_target = {cur_ff.latch[LATCH_HI:LATCH_LO],
            target_field(cur_ff.ir)};
        ctl_out.push_data = cur_ff.ret;
        ctl_out.rf_we = 1'b0;
        ctl_out.z_set = 1'b0;
        ctl_out.pc_load = 1'b0;
        ctl_out.push = 1'b0;
        ctl_out.discard = 1'b0;
        ctl_out.nop_slot = (cur_ff.slot == SLOT_NOP);
        ctl_out.foreign = 1'b0;
        // only clear touches the zero flag; skip and call leave flags
        unique case (op)
            OP_SKIP:
            begin
                ctl_out.discard = bit_val;
            end
            OP_CLEAR:
            begin
                ctl_out.rf_we = 1'b1;
                ctl_out.z_set = 1'b1;
            end
            OP_CALL:
            begin
                ctl_out.pc_load = 1'b1;
                ctl_out.push = 1'b1;
                ctl_out.discard = 1'b1;
            end
            OP_OTHER:
            begin
                ctl_out.foreign = (cur_ff.slot == SLOT_EXEC);
            end
        endcase
    end

endmodule : op_exec

// file: test/op_exec_monitor.sv
module op_exec_monitor
    import op_exec_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire fetch_t fetch_in,
    input wire logic [LW-1:0] upper_pc_latch_in,
    input wire logic [DW-1:0] rf_rdata_in,
    input wire ctl_t ctl_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    fetch_t f;
    ctl_t c;
    assign f = fetch_in;
    assign c = ctl_out;
    wire logic skp = f.vld && f.word[13:10] == 4'h7;
    wire logic clr = f.vld && f.word[13:7] == 7'h03;
    wire logic cal = f.vld && f.word[13:11] == 3'h4;
    chk_skip_test: assert property (skp |=> c.nop_slot ||
        c.discard == rf_rdata_in[$past(f.word[9:7])]) else $error("skip");
    chk_skip_flags: assert property (skp |=> !c.z_set && !c.rf_we)
        else $error("skip flags");
    chk_clear_zero: assert property (clr |=> c.nop_slot ||
        c.rf_we && c.z_set && c.rf_wdata == 8'h00 &&
        c.rf_addr == $past(f.word[6:0])) else $error("clear");
    chk_call_push: assert property (cal |=> c.nop_slot ||
        c.push && c.push_data == $past(f.pc) + 13'h1) else $error("push");
    chk_call_target: assert property (cal |=> c.nop_slot ||
        c.pc_load && c.pc_target == {$past(upper_pc_latch_in[4:3]),
        $past(f.word[10:0])}) else $error("target");
    chk_call_flags: assert property (c.pc_load |->
        !c.z_set && !c.rf_we && c.discard) else $error("call flags");
    chk_flush_nop: assert property (c.discard && f.vld |=> c.nop_slot)
        else $error("flush");
    chk_nop_quiet: assert property (c.nop_slot |->
        !(c.rf_we || c.push || c.pc_load || c.discard)) else $error("nop");
    cover property (c.discard);
    cover property (c.push);
    cover property (c.z_set);
endmodule : op_exec_monitor

bind op_exec op_exec_monitor mon (.clk_in(clk_in), .nrst_in(nrst_in),
    .fetch_in(fetch_in), .upper_pc_latch_in(upper_pc_latch_in),
    .rf_rdata_in(rf_rdata_in), .ctl_out(ctl_out));

// file: test/testbench.sv
module testbench
    import op_exec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    fetch_t fetch = '0;
    logic [LW-1:0] latch = '0;
    logic [DW-1:0] rdata = '0;
    ctl_t ctl;
    int num_errors = 0;
    int samples_checked = 0;
    wire logic [5:0] fl = {ctl.rf_we, ctl.z_set, ctl.pc_load, ctl.push,
        ctl.discard, ctl.nop_slot};
    op_exec uut (.clk_in(clk_in), .nrst_in(nrst_in), .fetch_in(fetch),
        .upper_pc_latch_in(latch), .rf_rdata_in(rdata), .ctl_out(ctl));
    always #25 clk_in = ~clk_in;
    task automatic check(input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e)
        begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, s, e);
        end
    endtask : check
    // drive one fetch word and the read data for the executing slot
    task automatic put(input logic [IW-1:0] w, input logic [PCW-1:0] p,
        input logic [LW-1:0] l, input logic [DW-1:0] d);
        @(posedge clk_in);
        #1;
        fetch = '{1'b1, w, p};
        latch = l;
        rdata = d;
        #1;
    endtask : put
    task automatic clear_case;
        put(14'h01d5, 13'h0020, 5'h00, 8'hff);
        put(14'h0000, 13'h0021, 5'h00, 8'hff);
        check(16'(fl), 16'h0030);
        check(16'({ctl.rf_addr, ctl.rf_wdata}), 16'h5500);
    endtask : clear_case
    task automatic skip_case(input logic b);
        put(14'h1e92, 13'h0010, 5'h00, 8'h00);
        put(14'h01d5, 13'h0011, 5'h00, {2'h0, b, 5'h00});
        check(16'(fl), 16'({4'h0, b, 1'b0}));
        check(16'(ctl.rf_addr), 16'h0012);
        put(14'h01d5, 13'h0012, 5'h00, 8'h00);
        check(16'(fl), b ? 16'h0001 : 16'h0030);
    endtask : skip_case
    task automatic call_case;
        put(14'h22ab, 13'h0100, 5'h18, 8'h00);
        put(14'h01d5, 13'h0101, 5'h00, 8'h00);
        check(16'(fl), 16'h000e);
        check(16'(ctl.pc_target), 16'h1aab);
        check(16'(ctl.push_data), 16'h0101);
        put(14'h0000, 13'h0aab, 5'h00, 8'h00);
        check(16'(fl), 16'h0001);
    endtask : call_case
    // a neighbouring opcode, then a reset in the execute cycle of a call
    task automatic other_case;
        put(14'h1a92, 13'h0030, 5'h00, 8'h00);
        put(14'h22ab, 13'h0031, 5'h18, 8'hff);
        check(16'({ctl.foreign, fl}), 16'h0040);
        @(posedge clk_in);
        #1;
        nrst_in = 1'b0;
        fetch = '0;
        #1;
        check(16'({ctl.foreign, fl}), 16'h0000);
        @(posedge clk_in);
        #1;
        nrst_in = 1'b1;
        put(14'h01d5, 13'h0032, 5'h00, 8'h00);
        put(14'h0000, 13'h0033, 5'h00, 8'h00);
        check(16'({ctl.foreign, fl}), 16'h0030);
    endtask : other_case
    task automatic conclude;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    initial
    begin
        repeat (20) @(posedge clk_in);
        #1;
        nrst_in = 1'b1;
        clear_case();
        skip_case(1'b1);
        skip_case(1'b0);
        call_case();
        other_case();
        conclude();
    end
endmodule : testbench
